// >>> inc/cpu_exec_pkg.sv
// Shared constants and types of the bit-operation and data-transfer execution block.
// Assumes one clock domain; the instruction decoder outside supplies decoded fields.
package cpu_exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int RB_AW  = 6;

  typedef enum logic [3:0] {
    OP_NOP                    = 4'h0,
    OP_ARITH_SHIFT_RIGHT      = 4'h1,
    OP_FLAG_FROM_BIT          = 4'h2,
    OP_BIT_FROM_FLAG          = 4'h3,
    OP_BSET                   = 4'h4,
    OP_BCLR                   = 4'h5,
    OP_LD                     = 4'h6,
    OP_ST                     = 4'h7,
    OP_LOAD_DIRECT            = 4'h8,
    OP_WRITE_DIRECT           = 4'h9,
    OP_PROGRAM_MEMORY_READ    = 4'ha,
    OP_PROGRAM_MEMORY_READ_R0 = 4'hb,
    OP_PUSH                   = 4'hc,
    OP_POP                    = 4'hd,
    OP_WATCHDOG_RESTART       = 4'he,
    OP_BREAK                  = 4'hf
  } op_t;

  typedef enum logic [1:0] {
    AM_PLAIN   = 2'h0,
    AM_POSTINC = 2'h1,
    AM_PREDEC  = 2'h2,
    AM_DISP    = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } ptr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MEM  = 2'h1,
    ST_PM1  = 2'h2,
    ST_PM2  = 2'h3
  } state_t;

  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  localparam logic [RB_AW-1:0]  RB_STATUS = 6'h20;
  localparam logic [RB_AW-1:0]  RB_SP_LO  = 6'h21;
  localparam logic [RB_AW-1:0]  RB_SP_HI  = 6'h22;
  localparam logic [7:0]        STATUS_RST = 8'h00;
  localparam logic [ADDR_W-1:0] SP_RST     = 16'h01ff;

  localparam int CYC_ONE  = 1;
  localparam int CYC_DATA = 2;
  localparam int CYC_PROG = 3;
endpackage

// >>> inc/ptr_step_if.sv
// Carries a 16-bit pointer to the step unit and its stepped value back.
// Assumes a purely combinational step unit on the far modport.
`timescale 1ns/1ps
`default_nettype none
interface ptr_step_if;
  logic [15:0] val;
  logic        dec;
  logic [15:0] res;
  modport user (output val, output dec, input res);
  modport step (input val, input dec, output res);
endinterface
`default_nettype wire

// >>> rtl/ptr_step.sv
// Steps a 16-bit pointer pair by one, up or down, byte by byte.
// Assumes the caller holds val and dec stable for the cycle it uses res.
`timescale 1ns/1ps
`default_nettype none
module ptr_step (
  ptr_step_if.step p
);
  logic [7:0] lo;
  logic       cy;

  always_comb begin
    lo = p.dec ? 8'(p.val[7:0] - 8'h01) : 8'(p.val[7:0] + 8'h01);
    // Carry or borrow crosses into the high byte
    cy = p.dec ? (p.val[7:0] == 8'h00) : (p.val[7:0] == 8'hff);
    p.res = {p.dec ? 8'(p.val[15:8] - {7'h00, cy}) : 8'(p.val[15:8] + {7'h00, cy}), lo};
  end
endmodule
`default_nettype wire

// >>> rtl/cpu_bitop_transfer_exec.sv
// Execution of shift, bit-transfer, flag, load/store, stack and control operations.
// Assumes decoded fields from an outside decoder; memories answer as in the port notes.
// What this block does
// - Arithmetic shift right, flags Z C N V, one cycle
// - Copy register bit into T flag only
// - Copy T flag into register bit, flags kept
// - Force overflow flag, nothing else changed
// - Force half-carry flag, nothing else changed
// - Force signed-test flag, nothing else changed
// - Indirect load then pointer plus one, two cycles
// - Pointer minus one then indirect load, two cycles
// - Load at Y or Z plus offset, pointer kept
// - Indirect store then pointer plus one, two cycles
// - Pointer minus one then indirect store, two cycles
// - Store at Y or Z plus offset, pointer kept
// - Direct load from constant address, two cycles
// - Direct store to constant address, two cycles
// - Program memory read via Z, three cycles
// - Stack put in two cycles, flags kept
// - Stack take in two cycles, flags kept
// - Watchdog restart in one cycle, flags kept
// - Debug break only when debugging, flags kept
`timescale 1ns/1ps
`default_nettype none
module cpu_bitop_transfer_exec #(
  parameter logic [15:0] SP_RESET = cpu_exec_pkg::SP_RST
) (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           instr_valid,
  input  wire cpu_exec_pkg::op_t              instr_op,
  input  wire logic [4:0]                     instr_rd,
  input  wire logic [4:0]                     instr_rr,
  input  wire logic [2:0]                     instr_bit,
  input  wire cpu_exec_pkg::ptr_t             instr_ptr,
  input  wire cpu_exec_pkg::mode_t            instr_mode,
  input  wire logic [5:0]                     instr_q,
  input  wire logic [15:0]                    instr_k,
  input  wire logic                           dbg_en,
  output logic                                ready_q,
  output logic                                done_q,
  output logic [15:0]                         dmem_addr_q,
  output logic [7:0]                          dmem_wdata_q,
  output logic                                dmem_we_q,
  output logic                                dmem_re_q,
  input  wire logic [7:0]                     dmem_rdata,
  output logic [15:0]                         pmem_addr_q,
  output logic                                pmem_re_q,
  input  wire logic [7:0]                     pmem_rdata,
  output logic                                wdt_restart_q,
  output logic                                dbg_break_q,
  output logic [7:0]                          status_q,
  input  wire logic [cpu_exec_pkg::RB_AW-1:0] rb_addr,
  input  wire logic [7:0]                     rb_wdata,
  input  wire logic                           rb_we,
  input  wire logic                           rb_re,
  output logic [7:0]                          rb_rdata_q
);
  import cpu_exec_pkg::*;

  logic [7:0]  regs_q [32];
  logic [15:0] sp_q;
  state_t      state_q;
  logic [4:0]  dest_q;
  logic        ld_q;

  logic        acc;
  logic [4:0]  ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] eff_addr;
  logic        is_load;
  logic        is_store;
  logic        is_pm_read;
  logic        ptr_upd;
  logic [7:0]  rd_b;
  logic [7:0]  rr_b;
  logic [7:0]  shift_res;

  ptr_step_if ps ();
  ptr_step_if ss ();

  ptr_step u_ptr_step (
    .p (ps.step)
  );

  ptr_step u_sp_step (
    .p (ss.step)
  );

  assign acc    = instr_valid && ready_q;
  assign is_pm_read = instr_op inside {OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_R0};
  assign rd_b   = regs_q[instr_rd];
  assign rr_b   = regs_q[instr_rr];
  assign shift_res = {rd_b[7], rd_b[7:1]};

  always_comb begin
    if (is_pm_read) begin
      ptr_lo = PTR_Z_LO;
    end else begin
      unique case (instr_ptr)
        PTR_X:   ptr_lo = PTR_X_LO;
        PTR_Y:   ptr_lo = PTR_Y_LO;
        PTR_Z:   ptr_lo = PTR_Z_LO;
        default: ptr_lo = PTR_X_LO;
      endcase
    end
  end

  assign ptr_val = {regs_q[5'(ptr_lo + 5'h01)], regs_q[ptr_lo]};
  assign ps.val  = ptr_val;
  assign ps.dec  = (instr_mode == AM_PREDEC) && !is_pm_read;
  assign ss.val  = sp_q;
  // Put writes at the stack top then moves down; take moves up first
  assign ss.dec  = (instr_op == OP_PUSH);

  assign is_load  = instr_op inside {OP_LD, OP_LOAD_DIRECT, OP_POP};
  assign is_store = instr_op inside {OP_ST, OP_WRITE_DIRECT, OP_PUSH};
  assign ptr_upd  = (((instr_op == OP_LD) || (instr_op == OP_ST))
                    && ((instr_mode == AM_POSTINC) || (instr_mode == AM_PREDEC)))
                    || ((instr_op == OP_PROGRAM_MEMORY_READ)
                    && (instr_mode == AM_POSTINC));

  always_comb begin
    unique case (instr_op)
      OP_LOAD_DIRECT, OP_WRITE_DIRECT: eff_addr = instr_k;
      OP_PUSH:        eff_addr = sp_q;
      OP_POP:         eff_addr = ss.res;
      default: begin
        if (instr_mode == AM_PREDEC) begin
          eff_addr = ps.res;
        end else if (instr_mode == AM_DISP && instr_ptr != PTR_X) begin
          eff_addr = 16'(ptr_val + {10'h000, instr_q});
        end else begin
          eff_addr = ptr_val;
        end
      end
    endcase
  end

  // Sequencer: one state per extra cycle an operation needs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
      dest_q  <= 5'h00;
      ld_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (acc) begin
            dest_q <= (instr_op == OP_PROGRAM_MEMORY_READ_R0) ? 5'h00 : instr_rd;
            ld_q   <= is_load;
            if (is_load || is_store) begin
              state_q <= ST_MEM;
              ready_q <= 1'b0;
            end else if (is_pm_read) begin
              state_q <= ST_PM1;
              ready_q <= 1'b0;
            end else begin
              done_q <= 1'b1;
            end
          end
        end
        ST_MEM: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
          done_q  <= 1'b1;
        end
        ST_PM1: state_q <= ST_PM2;
        ST_PM2: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
          done_q  <= 1'b1;
        end
      endcase
    end
  end

  // Memory strobes stand for exactly the one access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmem_addr_q  <= 16'h0000;
      dmem_wdata_q <= 8'h00;
      dmem_we_q    <= 1'b0;
      dmem_re_q    <= 1'b0;
      pmem_addr_q  <= 16'h0000;
      pmem_re_q    <= 1'b0;
    end else begin
      dmem_we_q <= acc && is_store;
      dmem_re_q <= acc && is_load;
      pmem_re_q <= acc && is_pm_read;
      if (acc && (is_load || is_store)) begin
        dmem_addr_q  <= eff_addr;
        dmem_wdata_q <= rr_b;
      end
      if (acc && is_pm_read) begin
        pmem_addr_q <= ptr_val;
      end
    end
  end

  // Register file; exec writes come last so they win over the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      if (rb_we && rb_addr < RB_STATUS) begin
        regs_q[rb_addr[4:0]] <= rb_wdata;
      end
      if (acc && ptr_upd) begin
        regs_q[ptr_lo]                <= ps.res[7:0];
        regs_q[5'(ptr_lo + 5'h01)]    <= ps.res[15:8];
      end
      if (acc && instr_op == OP_ARITH_SHIFT_RIGHT) begin
        regs_q[instr_rd] <= shift_res;
      end
      if (acc && instr_op == OP_BIT_FROM_FLAG) begin
        regs_q[instr_rd][instr_bit] <= status_q[FLG_T];
      end
      if (state_q == ST_MEM && ld_q) begin
        regs_q[dest_q] <= dmem_rdata;
      end
      if (state_q == ST_PM2) begin
        regs_q[dest_q] <= pmem_rdata;
      end
    end
  end

  // Status flags; only shift, bit store, flag force and register port writes touch them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= STATUS_RST;
    end else begin
      if (rb_we && rb_addr == RB_STATUS) begin
        status_q <= rb_wdata;
      end
      if (acc) begin
        unique case (instr_op)
          OP_ARITH_SHIFT_RIGHT: begin
            status_q[FLG_C] <= rd_b[0];
            status_q[FLG_N] <= shift_res[7];
            status_q[FLG_Z] <= (shift_res == 8'h00);
            status_q[FLG_V] <= shift_res[7] ^ rd_b[0];
          end
          OP_FLAG_FROM_BIT: status_q[FLG_T] <= rr_b[instr_bit];
          OP_BSET: status_q[instr_bit] <= 1'b1;
          OP_BCLR: status_q[instr_bit] <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sp_q <= SP_RESET;
    end else begin
      if (rb_we && rb_addr == RB_SP_LO) begin
        sp_q[7:0] <= rb_wdata;
      end
      if (rb_we && rb_addr == RB_SP_HI) begin
        sp_q[15:8] <= rb_wdata;
      end
      if (acc && (instr_op == OP_PUSH || instr_op == OP_POP)) begin
        sp_q <= ss.res;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_restart_q <= 1'b0;
      dbg_break_q   <= 1'b0;
    end else begin
      wdt_restart_q <= acc && instr_op == OP_WATCHDOG_RESTART;
      dbg_break_q   <= acc && instr_op == OP_BREAK && dbg_en;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_rdata_q <= 8'h00;
    end else begin
      rb_rdata_q <= 8'h00;
      if (rb_re) begin
        if (rb_addr < RB_STATUS) begin
          rb_rdata_q <= regs_q[rb_addr[4:0]];
        end else if (rb_addr == RB_STATUS) begin
          rb_rdata_q <= status_q;
        end else if (rb_addr == RB_SP_LO) begin
          rb_rdata_q <= sp_q[7:0];
        end else if (rb_addr == RB_SP_HI) begin
          rb_rdata_q <= sp_q[15:8];
        end
      end
    end
  end

  // Checking helpers, read only by the assertions
  logic [15:0] post_val;
  logic        shift_c;
  logic        t_src_bit;
  logic        t_flag;
  logic        force_val;
  logic [1:0]  len_q;
  logic        quiet;
  assign post_val  = 16'(ptr_val + 16'h0001);
  assign shift_c   = rd_b[0];
  assign t_src_bit = rr_b[instr_bit];
  assign t_flag    = status_q[FLG_T];
  assign force_val = (instr_op == OP_BSET);
  assign quiet     = !rb_we;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_q <= 2'h0;
    end else if (acc) begin
      len_q <= 2'h1;
    end else if (!ready_q) begin
      len_q <= 2'(len_q + 2'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_data_acc;
    acc && (is_load || is_store) && quiet;
  endsequence
  sequence s_data_done;
    !ready_q && (dmem_re_q || dmem_we_q) ##1 ready_q && done_q && !dmem_re_q && !dmem_we_q;
  endsequence
  sequence s_prog_done;
    pmem_re_q && !ready_q ##1 !pmem_re_q && !ready_q ##1 ready_q && done_q;
  endsequence

  a_shift_value: assert property (
    acc && instr_op == OP_ARITH_SHIFT_RIGHT && quiet |=>
      regs_q[$past(instr_rd)] == $past(shift_res)
  ) else $error("shift result wrong");
  a_shift_flags: assert property (
    acc && instr_op == OP_ARITH_SHIFT_RIGHT && quiet |=>
      status_q[FLG_C] == $past(shift_c) && status_q[FLG_V] == (status_q[FLG_N] ^ status_q[FLG_C])
  ) else $error("shift flags wrong");
  a_t_get_only: assert property (
    acc && instr_op == OP_FLAG_FROM_BIT && quiet |=> status_q[FLG_T] == $past(t_src_bit)
      && ((status_q ^ $past(status_q)) & 8'hbf) == 8'h00
  ) else $error("bit store flag wrong");
  a_t_put_keep: assert property (
    acc && instr_op == OP_BIT_FROM_FLAG && quiet |=> $stable(status_q)
      && regs_q[$past(instr_rd)][$past(instr_bit)] == $past(t_flag)
  ) else $error("bit load wrong");
  a_flag_force: assert property (
    acc && (instr_op == OP_BSET || instr_op == OP_BCLR) && quiet |=>
      status_q[$past(instr_bit)] == $past(force_val)
  ) else $error("flag force wrong");
  a_data_two_cycles: assert property (
    s_data_acc |=> s_data_done
  ) else $error("data transfer length wrong");
  a_data_length: assert property (
    done_q && $past(state_q) == ST_MEM |-> $past(len_q) == 2'(CYC_DATA - 1)
  ) else $error("data cycle count wrong");
  a_prog_three: assert property (
    acc && is_pm_read |=> s_prog_done
  ) else $error("program read length wrong");
  a_ptr_postinc: assert property (
    acc && ptr_upd && !ps.dec && quiet |=>
      {regs_q[5'($past(ptr_lo) + 5'h01)], regs_q[$past(ptr_lo)]} == $past(post_val)
  ) else $error("pointer step wrong");
  // A second restart taken back to back may hold the pulse up legally
  a_watchdog_pulse: assert property (
    acc && instr_op == OP_WATCHDOG_RESTART && quiet |=> wdt_restart_q && $stable(status_q)
      ##1 (!wdt_restart_q || $past(acc && instr_op == OP_WATCHDOG_RESTART))
  ) else $error("watchdog restart wrong");
  a_break_gated: assert property (
    dbg_break_q |-> $past(dbg_en) && $past(acc)
  ) else $error("break without debug");
endmodule
`default_nettype wire

// >>> testbench/exec_mem_model.sv
// Far side of the block: data memory with a same-cycle read, program memory one cycle late.
// Assumes one clock; access counts and last addresses are left for the bench to inspect.
`timescale 1ns/1ps
`default_nettype none
module exec_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] dmem_addr_q,
  input  wire logic [7:0]  dmem_wdata_q,
  input  wire logic        dmem_we_q,
  input  wire logic        dmem_re_q,
  output logic [7:0]       dmem_rdata,
  input  wire logic [15:0] pmem_addr_q,
  input  wire logic        pmem_re_q,
  output logic [7:0]       pmem_rdata
);
  logic [7:0]  mem [0:65535];
  logic [15:0] t;
  logic [7:0]  junk_q     = 8'h3c;
  int          n_rd       = 0;
  int          n_wr       = 0;
  logic [15:0] last_addr  = 16'h0;
  logic [15:0] last_paddr = 16'h0;

  initial begin
    pmem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      t = 16'(i);
      mem[i] = t[7:0] ^ t[15:8] ^ 8'ha5;
    end
  end

  // Outside a read the bus churns so a late sample cannot pass by luck
  assign dmem_rdata = dmem_re_q ? mem[dmem_addr_q] : junk_q;

  always @(posedge clk) begin
    junk_q <= ~junk_q;
    if (dmem_we_q) begin
      mem[dmem_addr_q] <= dmem_wdata_q;
      n_wr <= n_wr + 1;
      last_addr <= dmem_addr_q;
    end
    if (dmem_re_q) begin
      n_rd <= n_rd + 1;
      last_addr <= dmem_addr_q;
    end
    if (pmem_re_q) begin
      pmem_rdata <= pmem_addr_q[7:0] + pmem_addr_q[15:8] + 8'h3c;
      last_paddr <= pmem_addr_q;
    end else begin
      pmem_rdata <= ~pmem_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_cpu_bitop_transfer_exec.sv
// Self-checking bench for the execution block against a reference model.
// Assumes the memory model beside the block and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_bitop_transfer_exec;
  import cpu_exec_pkg::*;
  logic        clk         = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        instr_valid = 1'b0;
  op_t         instr_op    = OP_NOP;
  logic [4:0]  instr_rd    = 5'h0;
  logic [4:0]  instr_rr    = 5'h0;
  logic [2:0]  instr_bit   = 3'h0;
  ptr_t        instr_ptr   = PTR_X;
  mode_t       instr_mode  = AM_PLAIN;
  logic [5:0]  instr_q     = 6'h0;
  logic [15:0] instr_k     = 16'h0;
  logic        dbg_en      = 1'b0;
  logic [5:0]  rb_addr     = 6'h0;
  logic [7:0]  rb_wdata    = 8'h0;
  logic        rb_we       = 1'b0;
  logic        rb_re       = 1'b0;
  logic        ready_q, done_q, dmem_we_q, dmem_re_q, pmem_re_q, wdt_restart_q, dbg_break_q;
  logic [15:0] dmem_addr_q, pmem_addr_q, kk;
  logic [7:0]  dmem_wdata_q, dmem_rdata, pmem_rdata, status_q, rb_rdata_q, v;
  logic [7:0]  rf [32];
  logic [7:0]  sr;
  logic [15:0] sp;
  logic [7:0]  dm [int];
  logic [7:0]  shift_v [6] = '{8'h80, 8'h01, 8'h00, 8'hff, 8'h7e, 8'h35};
  int          mismatches = 0;
  int          n_compared = 0;

  always #50 clk = ~clk;

  cpu_bitop_transfer_exec dut_u (
    .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_rd(instr_rd), .instr_rr(instr_rr), .instr_bit(instr_bit), .instr_ptr(instr_ptr),
    .instr_mode(instr_mode), .instr_q(instr_q), .instr_k(instr_k), .dbg_en(dbg_en),
    .ready_q(ready_q), .done_q(done_q), .dmem_addr_q(dmem_addr_q),
    .dmem_wdata_q(dmem_wdata_q), .dmem_we_q(dmem_we_q), .dmem_re_q(dmem_re_q),
    .dmem_rdata(dmem_rdata), .pmem_addr_q(pmem_addr_q), .pmem_re_q(pmem_re_q),
    .pmem_rdata(pmem_rdata), .wdt_restart_q(wdt_restart_q), .dbg_break_q(dbg_break_q),
    .status_q(status_q), .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_we(rb_we),
    .rb_re(rb_re), .rb_rdata_q(rb_rdata_q));

  exec_mem_model mem_u (
    .clk(clk), .dmem_addr_q(dmem_addr_q), .dmem_wdata_q(dmem_wdata_q),
    .dmem_we_q(dmem_we_q), .dmem_re_q(dmem_re_q), .dmem_rdata(dmem_rdata),
    .pmem_addr_q(pmem_addr_q), .pmem_re_q(pmem_re_q), .pmem_rdata(pmem_rdata));

  function automatic logic [7:0] dmv(logic [15:0] a);
    return dm.exists(a) ? dm[a] : (a[7:0] ^ a[15:8] ^ 8'ha5);
  endfunction

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rb_wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    rb_we <= 1'b1;
    rb_addr <= a;
    rb_wdata <= d;
    @(posedge clk);
    rb_we <= 1'b0;
  endtask

  task automatic rb_rd(logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    rb_re <= 1'b1;
    rb_addr <= a;
    @(posedge clk);
    rb_re <= 1'b0;
    #1;
    d = rb_rdata_q;
  endtask

  // Addresses 0x00-0x22 map straight onto the loop index
  task automatic check_all();
    for (int i = 0; i < 35; i++) begin
      rb_rd(6'(i), v);
      chk($sformatf("reg %0d", i), i < 32 ? rf[i] : i == 32 ? sr : i == 33 ? sp[7:0] : sp[15:8], v);
    end
    chk("status port", sr, status_q);
  endtask

  task automatic set_ptr(int p, logic [15:0] val);
    rf[26 + 2 * p] = val[7:0];
    rf[27 + 2 * p] = val[15:8];
    rb_wr(6'(26 + 2 * p), val[7:0]);
    rb_wr(6'(27 + 2 * p), val[15:8]);
  endtask

  task automatic run(op_t op, logic [4:0] rd = 5'h0, logic [4:0] rr = 5'h0, logic [2:0] b = 3'h0,
                     ptr_t p = PTR_Z, mode_t m = AM_PLAIN, logic [5:0] q = 6'h0,
                     logic [15:0] k = 16'h0);
    int lo, cyc, nw, nb, nr, ncyc, r0, w0;
    logic [15:0] pv, a;
    logic [7:0] r;
    logic pm;
    pm = op inside {OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_R0};
    lo = 26 + 2 * int'(p);
    pv = {rf[lo + 1], rf[lo]};
    a = pv;
    nw = 0;
    nb = 0;
    nr = 0;
    r0 = mem_u.n_rd;
    w0 = mem_u.n_wr;
    ncyc = pm ? 3 : (op >= OP_LD && op <= OP_POP) ? 2 : 1;
    case (op)
      OP_ARITH_SHIFT_RIGHT: begin
        r = rf[rd];
        rf[rd] = {r[7], r[7:1]};
        sr[FLG_C] = r[0];
        sr[FLG_Z] = (rf[rd] == 8'h00);
        sr[FLG_N] = r[7];
        sr[FLG_V] = r[7] ^ r[0];
      end
      OP_FLAG_FROM_BIT: sr[FLG_T] = rf[rr][b];
      OP_BIT_FROM_FLAG: rf[rd][b] = sr[FLG_T];
      OP_BSET: sr[b] = 1'b1;
      OP_BCLR: sr[b] = 1'b0;
      OP_LD, OP_ST: begin
        if (m == AM_PREDEC) pv = pv - 16'h1;
        a = (m == AM_DISP && p != PTR_X) ? pv + 16'(q) : pv;
        if (m == AM_POSTINC) pv = pv + 16'h1;
      end
      OP_PROGRAM_MEMORY_READ: if (m == AM_POSTINC) pv = pv + 16'h1;
      OP_LOAD_DIRECT, OP_WRITE_DIRECT: a = k;
      OP_PUSH: begin
        a = sp;
        sp = sp - 16'h1;
      end
      OP_POP: begin
        sp = sp + 16'h1;
        a = sp;
      end
      default: ;
    endcase
    if (op inside {OP_LD, OP_ST, OP_PROGRAM_MEMORY_READ}) {rf[lo + 1], rf[lo]} = pv;
    if (op inside {OP_LD, OP_LOAD_DIRECT, OP_POP}) rf[rd] = dmv(a);
    if (op inside {OP_ST, OP_WRITE_DIRECT, OP_PUSH}) dm[a] = rf[rr];
    if (pm) rf[op == OP_PROGRAM_MEMORY_READ_R0 ? 0 : rd] = a[7:0] + a[15:8] + 8'h3c;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_rd <= rd;
    instr_rr <= rr;
    instr_bit <= b;
    instr_ptr <= p;
    instr_mode <= m;
    instr_q <= q;
    instr_k <= k;
    @(posedge clk);
    instr_valid <= 1'b0;
    for (cyc = 1; cyc < 6; cyc++) begin
      #1;
      nw += int'(wdt_restart_q === 1'b1);
      nb += int'(dbg_break_q === 1'b1);
      if (done_q === 1'b1) break;
      nr += int'(ready_q !== 1'b0);
      @(posedge clk);
    end
    chk("cycles", 16'(ncyc), 16'(cyc));
    chk("ready while busy", 16'h0, 16'(nr));
    chk("watchdog pulses", 16'(op == OP_WATCHDOG_RESTART), 16'(nw));
    chk("break pulses", 16'(op == OP_BREAK && dbg_en), 16'(nb));
    chk("data reads", 16'(op inside {OP_LD, OP_LOAD_DIRECT, OP_POP}), 16'(mem_u.n_rd - r0));
    chk("data writes", 16'(op inside {OP_ST, OP_WRITE_DIRECT, OP_PUSH}), 16'(mem_u.n_wr - w0));
    if (op >= OP_LD && op <= OP_POP && !pm) chk("data addr", a, mem_u.last_addr);
    if (pm) chk("program addr", a, mem_u.last_paddr);
    check_all();
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("watchdog expired before the tests ended");
    wrap_up();
  end

  initial begin
    void'($urandom(47627));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rf[i]) rf[i] = 8'h00;
    sr = STATUS_RST;
    sp = SP_RST;
    check_all();
    rb_wr(6'h3f, 8'hff);
    rb_rd(6'h3f, v);
    chk("unmapped read", 16'h0, v);
    for (int i = 0; i < 33; i++) begin
      v = 8'($urandom);
      if (i < 32) rf[i] = v;
      else sr = v;
      rb_wr(6'(i), v);
    end
    check_all();
    $display("test reset and register port done");
    for (int i = 0; i < 6; i++) begin
      rf[3] = shift_v[i];
      rb_wr(6'h03, shift_v[i]);
      run(OP_ARITH_SHIFT_RIGHT, 5'h3);
    end
    for (int b = 0; b < 8; b++) begin
      run(OP_FLAG_FROM_BIT, 5'h0, 5'h5, 3'(b));
      run(OP_BIT_FROM_FLAG, 5'h6, 5'h0, 3'(7 - b));
      run(OP_BSET, 5'h0, 5'h0, 3'(b));
      run(OP_BCLR, 5'h0, 5'h0, 3'(b));
    end
    $display("test bit and flag operations done");
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        set_ptr(p, m == 2 ? 16'h0100 : 16'h00ff);
        run(OP_LD, 5'($urandom % 26), 5'h0, 3'h0, ptr_t'(p), mode_t'(m), 6'($urandom));
        run(OP_ST, 5'h0, 5'($urandom % 26), 3'h0, ptr_t'(p), mode_t'(m), 6'($urandom));
      end
    end
    kk = 16'($urandom);
    run(OP_WRITE_DIRECT, 5'h0, 5'ha, 3'h0, PTR_Z, AM_PLAIN, 6'h0, kk);
    run(OP_LOAD_DIRECT, 5'hb, 5'h0, 3'h0, PTR_Z, AM_PLAIN, 6'h0, kk);
    run(OP_LOAD_DIRECT, 5'h9, 5'h0, 3'h0, PTR_Z, AM_PLAIN, 6'h0, 16'($urandom));
    $display("test loads and stores done");
    set_ptr(2, 16'h00ff);
    run(OP_PROGRAM_MEMORY_READ_R0);
    run(OP_PROGRAM_MEMORY_READ, 5'hc, 5'h0, 3'h0, PTR_Z, AM_PLAIN);
    run(OP_PROGRAM_MEMORY_READ, 5'hd, 5'h0, 3'h0, PTR_Z, AM_POSTINC);
    run(OP_PUSH, 5'h0, 5'h2);
    run(OP_PUSH, 5'h0, 5'h4);
    run(OP_POP, 5'h7);
    run(OP_POP, 5'h8);
    $display("test program memory and stack done");
    run(OP_WATCHDOG_RESTART);
    run(OP_BREAK);
    dbg_en <= 1'b1;
    run(OP_BREAK);
    $display("test control operations done");
    wrap_up();
  end
endmodule
`default_nettype wire
